// *** rsls_pkg.sv ***
// constants shared by the strap loader, led scanner and register slave
// assumes a 20 MHz core clock and a 32-bit register bus
//
// Overview of operation
// R01 - straps read from shared pins during reset
// R02 - led bit0 strap: single or dual memory
// R03 - led bit1 strap: 2 MB or 1 MB buffer
// R04 - led bit2 strap: memory self-test enable
// R05 - led bit3 strap: address aging enable
// R06 - led bit4 strap: phy polling enable
// R07 - led bit5 strap: broadcast storm control enable
// R08 - led bit6 strap: half-duplex backpressure enable
// R09 - led bit7 strap: full-duplex pause enable
// R10 - strobe a strap: 8K or 1K table
// R11 - strobe b strap: serial prom interface enable
// R12 - prom data strap: autoload needs prom interface
// R13 - tx enable [2:0] strap: uplink port
// R14 - tx enable 3 strap: flooding control enable
// R15 - tx enable 4 strap: 1522 byte vlan frames
// R16 - aux clock strap: port 4 mii or rmii
// R17 - prom clock strap: scan debug mode
// R18 - mdc strap: fast test mode
// R19 - led bus scans activity, then utilisation frames
// R20 - util bits 0-4: 5/10/20/35/50 percent
// R21 - util bit5 almost full, bit6 memtest fail
// R22 - system holds reset low to reset
// R23 - straps latched at release, held, pins released
package rsls_pkg;

    localparam int CLK_PERIOD_NS = 50;
    localparam int STB_WIDTH_NS  = 200;
    localparam int STB_CYC       = (STB_WIDTH_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int SETUP_NS      = 100;
    localparam int SETUP_CYC     = (SETUP_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;

    localparam int STRAP_W        = 19;
    localparam int F_LED_LO       = 0;
    localparam int F_MEM_SINGLE   = 0;
    localparam int F_BUF_2MB      = 1;
    localparam int F_MEM_TEST     = 2;
    localparam int F_AGING        = 3;
    localparam int F_PHY_POLL     = 4;
    localparam int F_BCAST        = 5;
    localparam int F_BACKPRESS    = 6;
    localparam int F_PAUSE        = 7;
    localparam int F_TABLE_8K     = 8;
    localparam int F_PROM_IF      = 9;
    localparam int F_AUTOLOAD     = 10;
    localparam int F_UPLINK_LO    = 11;
    localparam int F_FLOOD        = 14;
    localparam int F_VLAN1522     = 15;
    localparam int F_PORT4_MII    = 16;
    localparam int F_SCAN         = 17;
    localparam int F_FAST         = 18;
    localparam logic [STRAP_W-1:0] STRAP_RESET = 19'h007fd;

    localparam logic [7:0]  REG_STRAP    = 8'h00;
    localparam logic [7:0]  REG_LED_CTRL = 8'h04;
    localparam logic [7:0]  REG_LED_STAT = 8'h08;
    localparam int          C_EN         = 0;
    localparam int          C_INV        = 1;
    localparam int          C_GAP_LO     = 8;
    localparam logic [31:0] CTRL_RESET   = 32'h00001001;
    localparam logic [31:0] CTRL_MASK    = 32'h0000ff03;
    localparam int          S_DONE       = 16;
    localparam int          S_BUSY       = 17;

    localparam int         UTIL_N = 5;
    localparam logic [6:0] UTIL_THR [UTIL_N] =
        '{7'h05, 7'h0a, 7'h14, 7'h23, 7'h32};

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : rsls_pkg

// *** rsls_led_scan.sv ***
// led frame scanner: alternates activity and utilisation frames
// assumes frames come from logic on the same clock
`timescale 1ns/1ps
module rsls_led_scan (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       release_pins,
    input  wire logic       run,
    input  wire logic [7:0] gap,
    input  wire logic       invert,
    input  wire logic [7:0] frame_a,
    input  wire logic [7:0] frame_b,
    output logic      [7:0] led_data_r,
    output logic            strobe_a_r,
    output logic            strobe_b_r,
    output logic            drive_n_r,
    output logic            busy_r
);

    typedef enum logic [2:0] {
        SC_IDLE, SC_SET_A, SC_STB_A, SC_SET_B, SC_STB_B, SC_GAP
    } rsls_scan_state_type;

    localparam logic [7:0] SET_LAST = 8'(rsls_pkg::SETUP_CYC - 1);
    localparam logic [7:0] STB_LAST = 8'(rsls_pkg::STB_CYC - 1);

    rsls_scan_state_type state_r;
    rsls_scan_state_type state_nxt;
    logic [7:0]          cnt_r;
    logic [7:0]          cnt_nxt;
    logic [7:0]          led_data_nxt;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r + 8'h01;
        case (state_r)
            SC_IDLE: begin
                cnt_nxt = 8'h00;
                if (run) begin
                    state_nxt = SC_SET_A;
                end
            end
            SC_SET_A: if (cnt_r == SET_LAST) begin
                state_nxt = SC_STB_A;
                cnt_nxt   = 8'h00;
            end
            SC_STB_A: if (cnt_r == STB_LAST) begin
                state_nxt = SC_SET_B;
                cnt_nxt   = 8'h00;
            end
            SC_SET_B: if (cnt_r == SET_LAST) begin
                state_nxt = SC_STB_B;
                cnt_nxt   = 8'h00;
            end
            SC_STB_B: if (cnt_r == STB_LAST) begin
                state_nxt = SC_GAP;
                cnt_nxt   = 8'h00;
            end
            // gap may shrink while counting; never wait for a wrap
            SC_GAP: if (cnt_r >= gap) begin
                state_nxt = run ? SC_SET_A : SC_IDLE;
                cnt_nxt   = 8'h00;
            end
            default: begin
                state_nxt = SC_IDLE;
                cnt_nxt   = 8'h00;
            end
        endcase
    end

    // data is set up before each strobe and held through it
    always_comb begin
        led_data_nxt = led_data_r;
        if (state_nxt == SC_IDLE) begin
            led_data_nxt = {8{invert}};
        end else if (state_nxt == SC_SET_A && state_r != SC_SET_A) begin
            led_data_nxt = frame_a ^ {8{invert}}; // R19
        end else if (state_nxt == SC_SET_B && state_r != SC_SET_B) begin
            led_data_nxt = frame_b ^ {8{invert}}; // R19
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r    <= SC_IDLE;
            cnt_r      <= 8'h00;
            led_data_r <= 8'h00;
            strobe_a_r <= 1'b0;
            strobe_b_r <= 1'b0;
            busy_r     <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            cnt_r      <= cnt_nxt;
            led_data_r <= led_data_nxt;
            strobe_a_r <= (state_nxt == SC_STB_A); // R19
            strobe_b_r <= (state_nxt == SC_STB_B); // R19
            busy_r     <= (state_nxt != SC_IDLE);
        end
    end

    // pins stay released until the straps are taken
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            drive_n_r <= 1'b1;
        end else begin
            drive_n_r <= !release_pins; // R23
        end
    end

    sequence s_strobe_a_pulse;
        strobe_a_r [*4] ##1 !strobe_a_r;
    endsequence

    sequence s_then_b;
        !strobe_b_r [*2] ##1 strobe_b_r;
    endsequence

    a_strobe_a_width: assert property (@(posedge clk) disable iff (!rst_n) // R19
        $rose(strobe_a_r) |-> s_strobe_a_pulse)
        else $error("strobe a width wrong");

    a_strobe_b_follows: assert property (@(posedge clk) disable iff (!rst_n) // R19
        $fell(strobe_a_r) |-> s_then_b)
        else $error("strobe b does not follow strobe a");

    a_strobe_data_hold: assert property (@(posedge clk) disable iff (!rst_n) // R19
        (strobe_a_r || strobe_b_r) && $past(strobe_a_r || strobe_b_r)
        |-> $stable(led_data_r))
        else $error("led data moved during strobe");

endmodule : rsls_led_scan

// *** rsls_top.sv ***
// strap capture at reset release, led status output, axi4-lite registers
// assumes strap pins are pulled during reset and undriven by the board
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module rsls_top #(
    parameter int ADDR_W = 8
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic      [1:0]        s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic      [31:0]       s_axi_rdata,
    output logic      [1:0]        s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [7:0]        status_led_bus_i,
    output logic      [7:0]        status_led_bus_o,
    output logic      [7:0]        status_led_bus_oe_n,
    input  wire logic              led_strobe_a_i,
    output logic                   led_strobe_a_o,
    output logic                   led_strobe_a_oe_n,
    input  wire logic              led_strobe_b_i,
    output logic                   led_strobe_b_o,
    output logic                   led_strobe_b_oe_n,
    input  wire logic              prom_serial_data_i,
    input  wire logic              prom_serial_clock_i,
    input  wire logic [4:0]        port_tx_enable_i,
    input  wire logic              aux_serial_clock_i,
    input  wire logic              mdc_i,
    input  wire logic [4:0]        link_rx_activity,
    input  wire logic [6:0]        buffer_use_pct,
    input  wire logic              buffer_almost_full,
    input  wire logic              mem_test_fail,
    output logic                   straps_done,
    output logic                   cfg_mem_single,
    output logic                   cfg_buf_2mb,
    output logic                   cfg_mem_test_en,
    output logic                   cfg_aging_en,
    output logic                   cfg_phy_poll_en,
    output logic                   cfg_bcast_storm_en,
    output logic                   cfg_backpressure_en,
    output logic                   cfg_pause_en,
    output logic                   cfg_table_8k,
    output logic                   cfg_prom_if_en,
    output logic                   cfg_autoload_en,
    output logic      [2:0]        cfg_uplink_port,
    output logic                   cfg_flood_ctrl_en,
    output logic                   cfg_vlan_1522_en,
    output logic                   cfg_port4_mii,
    output logic                   cfg_scan_mode,
    output logic                   cfg_fast_mode
);

    localparam int SW = rsls_pkg::STRAP_W;

    logic [SW-1:0] pin_s1_r;
    logic [SW-1:0] pin_s2_r;
    logic [SW-1:0] pin_raw;
    logic [SW-1:0] strap_cap;
    logic [SW-1:0] strap_r;
    logic          pend_r;
    logic          done_r;

    // pin order follows the strap field layout
    assign pin_raw = {mdc_i, prom_serial_clock_i, aux_serial_clock_i,
                      port_tx_enable_i, prom_serial_data_i,
                      led_strobe_b_i, led_strobe_a_i, status_led_bus_i};

    // two-stage synchroniser, runs through reset so levels are ready
    always_ff @(posedge aclk) begin
        pin_s1_r <= pin_raw; // R01
        pin_s2_r <= pin_s1_r;
    end

    always_comb begin
        strap_cap = pin_s2_r; // R01
        // autoload only counts when the prom interface is enabled
        strap_cap[rsls_pkg::F_AUTOLOAD] =
            pin_s2_r[rsls_pkg::F_AUTOLOAD]
            & pin_s2_r[rsls_pkg::F_PROM_IF]; // R12
    end

    // capture on the first edge after release, then hold until reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strap_r <= rsls_pkg::STRAP_RESET; // R22
            pend_r  <= 1'b1;
            done_r  <= 1'b0;
        end else if (pend_r) begin
            strap_r <= strap_cap; // R23
            pend_r  <= 1'b0;
            done_r  <= 1'b1;
        end
    end

    assign straps_done         = done_r;
    assign cfg_mem_single      = strap_r[rsls_pkg::F_MEM_SINGLE]; // R02
    assign cfg_buf_2mb         = strap_r[rsls_pkg::F_BUF_2MB]; // R03
    assign cfg_mem_test_en     = strap_r[rsls_pkg::F_MEM_TEST]; // R04
    assign cfg_aging_en        = strap_r[rsls_pkg::F_AGING]; // R05
    assign cfg_phy_poll_en     = strap_r[rsls_pkg::F_PHY_POLL]; // R06
    assign cfg_bcast_storm_en  = strap_r[rsls_pkg::F_BCAST]; // R07
    assign cfg_backpressure_en = strap_r[rsls_pkg::F_BACKPRESS]; // R08
    assign cfg_pause_en        = strap_r[rsls_pkg::F_PAUSE]; // R09
    assign cfg_table_8k        = strap_r[rsls_pkg::F_TABLE_8K]; // R10
    assign cfg_prom_if_en      = strap_r[rsls_pkg::F_PROM_IF]; // R11
    assign cfg_autoload_en     = strap_r[rsls_pkg::F_AUTOLOAD]; // R12
    assign cfg_uplink_port     =
        strap_r[rsls_pkg::F_UPLINK_LO +: 3]; // R13
    assign cfg_flood_ctrl_en   = strap_r[rsls_pkg::F_FLOOD]; // R14
    assign cfg_vlan_1522_en    = strap_r[rsls_pkg::F_VLAN1522]; // R15
    assign cfg_port4_mii       = strap_r[rsls_pkg::F_PORT4_MII]; // R16
    assign cfg_scan_mode       = strap_r[rsls_pkg::F_SCAN]; // R17
    assign cfg_fast_mode       = strap_r[rsls_pkg::F_FAST]; // R18

    // led frames
    logic [7:0] frame_a;
    logic [7:0] frame_b;
    logic [rsls_pkg::UTIL_N-1:0] util_bits;

    genvar gi;
    generate
        for (gi = 0; gi < rsls_pkg::UTIL_N; gi++) begin : g_util
            assign util_bits[gi] =
                (buffer_use_pct >= rsls_pkg::UTIL_THR[gi]); // R20
        end
    endgenerate

    assign frame_a = {3'h0, link_rx_activity}; // R19
    // memory failure only meaningful when the self-test ran
    assign frame_b = {1'b0, mem_test_fail & cfg_mem_test_en,
                      buffer_almost_full, util_bits}; // R21

    // register state
    logic [31:0] ctrl_r;
    logic [31:0] ctrl_nxt;
    logic        scan_busy;
    logic        scan_drive_n;

    rsls_led_scan u_scan (
        .clk          (aclk),
        .rst_n        (aresetn),
        .release_pins (done_r),
        .run          (done_r & ctrl_r[rsls_pkg::C_EN]),
        .gap          (ctrl_r[rsls_pkg::C_GAP_LO +: 8]),
        .invert       (ctrl_r[rsls_pkg::C_INV]),
        .frame_a      (frame_a),
        .frame_b      (frame_b),
        .led_data_r   (status_led_bus_o),
        .strobe_a_r   (led_strobe_a_o),
        .strobe_b_r   (led_strobe_b_o),
        .drive_n_r    (scan_drive_n),
        .busy_r       (scan_busy)
    );

    assign status_led_bus_oe_n = {8{scan_drive_n}}; // R23
    assign led_strobe_a_oe_n   = scan_drive_n; // R23
    assign led_strobe_b_oe_n   = scan_drive_n; // R23

    // axi4-lite write side: address and data taken in either order
    logic              aw_have_r;
    logic              aw_have_nxt;
    logic [ADDR_W-1:0] aw_addr_r;
    logic              w_have_r;
    logic              w_have_nxt;
    logic [31:0]       w_data_r;
    logic [3:0]        w_strb_r;
    logic              wr_fire;
    logic [7:0]        wr_off;
    logic [7:0]        rd_off;

    assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
    assign wr_off  = 8'({aw_addr_r[ADDR_W-1:2], 2'h0});
    assign rd_off  = 8'({s_axi_araddr[ADDR_W-1:2], 2'h0});

    always_comb begin
        aw_have_nxt = aw_have_r;
        w_have_nxt  = w_have_r;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have_nxt = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have_nxt = 1'b1;
        end
        if (wr_fire) begin
            aw_have_nxt = 1'b0;
            w_have_nxt  = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r     <= 1'b0;
            w_have_r      <= 1'b0;
            aw_addr_r     <= '0;
            w_data_r      <= 32'h00000000;
            w_strb_r      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            aw_have_r     <= aw_have_nxt;
            w_have_r      <= w_have_nxt;
            s_axi_awready <= !aw_have_nxt;
            s_axi_wready  <= !w_have_nxt;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
        end
    end

    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_fire && wr_off == rsls_pkg::REG_LED_CTRL) begin
            for (int b = 0; b < 4; b++) begin
                if (w_strb_r[b]) begin
                    ctrl_nxt[8*b +: 8] = w_data_r[8*b +: 8];
                end
            end
            ctrl_nxt = ctrl_nxt & rsls_pkg::CTRL_MASK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= rsls_pkg::CTRL_RESET;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= rsls_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            if (wr_off == rsls_pkg::REG_STRAP ||
                wr_off == rsls_pkg::REG_LED_CTRL ||
                wr_off == rsls_pkg::REG_LED_STAT) begin
                s_axi_bresp <= rsls_pkg::RESP_OKAY;
            end else begin
                s_axi_bresp <= rsls_pkg::RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // axi4-lite read side
    logic [31:0] stat_word;
    logic        rd_fire;

    assign rd_fire = s_axi_arvalid && s_axi_arready;

    always_comb begin
        stat_word = 32'h00000000;
        stat_word[7:0]              = frame_a;
        stat_word[15:8]             = frame_b;
        stat_word[rsls_pkg::S_DONE] = done_r;
        stat_word[rsls_pkg::S_BUSY] = scan_busy;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= rsls_pkg::RESP_OKAY;
        end else begin
            if (rd_fire) begin
                s_axi_rvalid  <= 1'b1;
                s_axi_arready <= 1'b0;
                s_axi_rresp   <= rsls_pkg::RESP_OKAY;
                case (rd_off)
                    rsls_pkg::REG_STRAP:
                        s_axi_rdata <= 32'(strap_r);
                    rsls_pkg::REG_LED_CTRL:
                        s_axi_rdata <= ctrl_r;
                    rsls_pkg::REG_LED_STAT:
                        s_axi_rdata <= stat_word;
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= rsls_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end else begin
                s_axi_arready <= !s_axi_rvalid;
            end
        end
    end

    // checks
    a_strap_capture: assert property (@(posedge aclk) disable iff (!aresetn) // R01
        pend_r |=> strap_r == $past(strap_cap) && done_r)
        else $error("straps not captured at release");

    a_strap_hold: assert property (@(posedge aclk) disable iff (!aresetn) // R23
        done_r |=> $stable(strap_r) && done_r)
        else $error("straps changed after capture");

    a_pins_released: assert property (@(posedge aclk) // R23
        !aresetn ##1 !aresetn |-> status_led_bus_oe_n == 8'hff
        && led_strobe_a_oe_n && led_strobe_b_oe_n)
        else $error("shared pins driven during reset");

    a_pins_driven: assert property (@(posedge aclk) disable iff (!aresetn) // R19
        $rose(done_r) |=> !led_strobe_a_oe_n && status_led_bus_oe_n == 8'h00)
        else $error("led pins not driven after capture");

    a_autoload_gate: assert property (@(posedge aclk) disable iff (!aresetn) // R12
        cfg_autoload_en |-> cfg_prom_if_en)
        else $error("autoload without prom interface");

    a_reset_defaults: assert property (@(posedge aclk) // R02
        !aresetn |=> cfg_mem_single && !cfg_buf_2mb && cfg_table_8k
        && cfg_uplink_port == 3'h0 && !cfg_port4_mii)
        else $error("strap defaults wrong in reset");

    a_util_full: assert property (@(posedge aclk) disable iff (!aresetn) // R20
        buffer_use_pct >= 7'h32 |-> frame_b[4:0] == 5'h1f)
        else $error("utilisation bits wrong at top level");

    a_util_low: assert property (@(posedge aclk) disable iff (!aresetn) // R20
        buffer_use_pct < 7'h05 |-> frame_b[4:0] == 5'h00)
        else $error("utilisation bits set below lowest level");

    a_alarm_bits: assert property (@(posedge aclk) disable iff (!aresetn) // R21
        frame_b[6:5] == {mem_test_fail && cfg_mem_test_en,
                         buffer_almost_full} && !frame_b[7])
        else $error("alarm bits misplaced");

endmodule : rsls_top

// *** rsls_board.sv ***
// board model: strap pull resistors and led latch drivers
// assumes enables active low, strobes active high
`timescale 1ns/1ps
module rsls_board (
    input  wire logic [9:0] pull,
    input  wire logic [9:0] drv,
    input  wire logic [9:0] oe_n,
    output logic      [9:0] pin,
    output logic      [7:0] act_q,
    output logic      [7:0] util_q
);
    // released pins fall back to their pull level
    assign pin = (oe_n & pull) | (~oe_n & drv);
    always @(posedge pin[8]) act_q <= pin[7:0];
    always @(posedge pin[9]) util_q <= pin[7:0];
endmodule : rsls_board

// *** tb.sv ***
// self-checking bench: strap rows, led frames, register access
// assumes rsls_top with default address width
`timescale 1ns/1ps
module tb;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, got;
    logic [1:0]  bresp, rresp, resp;
    logic        awready, wready, bvalid, arready, rvalid, done, af, mf;
    logic [18:0] pins, cfg;
    logic [9:0]  drv, oe_n, pin;
    logic [7:0]  act_q, util_q;
    logic [4:0]  act;
    logic [6:0]  pct;
    int          n_mismatch = 0, checks_done = 0, cyc = 0;
    // pin levels, expected strap value
    logic [18:0] rows [4][2] = '{'{19'h7ffff, 19'h7ffff},
        '{19'h00000, 19'h00000}, '{19'h05502, 19'h05102},
        '{19'h007fd, 19'h007fd}};
    rsls_board BRD (.pull(pins[9:0]), .drv(drv), .oe_n(oe_n), .pin(pin),
        .act_q(act_q), .util_q(util_q));
    rsls_top DUT (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .status_led_bus_i(pin[7:0]),
        .status_led_bus_o(drv[7:0]), .status_led_bus_oe_n(oe_n[7:0]),
        .led_strobe_a_i(pin[8]), .led_strobe_a_o(drv[8]),
        .led_strobe_a_oe_n(oe_n[8]), .led_strobe_b_i(pin[9]),
        .led_strobe_b_o(drv[9]), .led_strobe_b_oe_n(oe_n[9]),
        .prom_serial_data_i(pins[10]), .prom_serial_clock_i(pins[17]),
        .port_tx_enable_i(pins[15:11]), .aux_serial_clock_i(pins[16]),
        .mdc_i(pins[18]), .link_rx_activity(act), .buffer_use_pct(pct),
        .buffer_almost_full(af), .mem_test_fail(mf), .straps_done(done),
        .cfg_mem_single(cfg[0]), .cfg_buf_2mb(cfg[1]),
        .cfg_mem_test_en(cfg[2]), .cfg_aging_en(cfg[3]),
        .cfg_phy_poll_en(cfg[4]), .cfg_bcast_storm_en(cfg[5]),
        .cfg_backpressure_en(cfg[6]), .cfg_pause_en(cfg[7]),
        .cfg_table_8k(cfg[8]), .cfg_prom_if_en(cfg[9]),
        .cfg_autoload_en(cfg[10]), .cfg_uplink_port(cfg[13:11]),
        .cfg_flood_ctrl_en(cfg[14]), .cfg_vlan_1522_en(cfg[15]),
        .cfg_port4_mii(cfg[16]), .cfg_scan_mode(cfg[17]),
        .cfg_fast_mode(cfg[18]));
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_mismatch++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        {awaddr, wdata} <= {a, d};
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        {got, resp} = {rdata, rresp};
        rready <= 1'b0;
    endtask : rd
    task automatic do_reset(input logic [18:0] p);
        {pins, aresetn} <= {p, 1'b0};
        repeat (8) @(posedge aclk);
        chk("cfg in reset", 32'(rsls_pkg::STRAP_RESET), 32'(cfg));
        chk("oe_n in reset", 32'h3ff, 32'(oe_n));
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
    endtask : do_reset
    task automatic led_chk(input logic [7:0] ea, input logic [7:0] eu);
        repeat (40) @(posedge aclk);
        chk("act frame", 32'(ea), 32'(act_q));
        chk("util frame", 32'(eu), 32'(util_q));
        $display("led frame test done");
    endtask : led_chk
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, aresetn} = '0;
        {awaddr, araddr, wdata, pins} = '0;
        {act, pct, af, mf} = {5'h15, 7'h23, 2'h3};
        foreach (rows[i]) begin
            do_reset(rows[i][0]);
            chk("straps_done", 32'h1, 32'(done));
            chk("cfg", 32'(rows[i][1]), 32'(cfg));
            rd(rsls_pkg::REG_STRAP);
            chk("strap reg", 32'(rows[i][1]), got);
            pins <= ~rows[i][0];
            repeat (3) @(posedge aclk);
            chk("cfg held", 32'(rows[i][1]), 32'(cfg));
            $display("strap row %0d done", i);
        end
        chk("pins driven", 32'h0, 32'(oe_n));
        wr(rsls_pkg::REG_LED_CTRL, 32'h00000101);
        chk("ctrl resp", 32'h0, 32'(resp));
        led_chk(8'h15, 8'h6f);
        {act, pct, af, mf} <= {5'h0a, 7'h32, 2'h0};
        led_chk(8'h0a, 8'h1f);
        rd(rsls_pkg::REG_LED_CTRL);
        chk("ctrl read", 32'h00000101, got);
        rd(rsls_pkg::REG_LED_STAT);
        chk("led stat", 32'h00031f0a, got);
        wr(rsls_pkg::REG_LED_CTRL, 32'h00000103);
        led_chk(8'hf5, 8'he0);
        rd(8'h40);
        chk("unmapped rresp", 32'h2, 32'(resp));
        chk("unmapped rdata", 32'h0, got);
        wr(8'h40, 32'hffffffff);
        chk("unmapped bresp", 32'h2, 32'(resp));
        wr(rsls_pkg::REG_STRAP, 32'h0);
        rd(rsls_pkg::REG_STRAP);
        chk("strap read only", 32'h000007fd, got);
        $display("register test done");
        final_report();
    end
endmodule : tb
